//--- rtl/sspc_top.sv
// SPI shift port with AXI4-Lite register access and interrupt
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module sspc_top
   import sspc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [sspc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [sspc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe,
   input wire logic scs_n_i,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe,
   output logic pins_claimed,
   output logic irq
);
   import sspc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Registers and state
   logic [CTRL_W-1:0] ctrl_q;
   logic trf_q, write_collision_flag_q;
   logic [7:0] shift_q, data_q;
   logic [3:0] cnt_q;
   logic busy_q;
   sspc_state_e st_q;
   sspc_state_e st_d;
   logic [7:0] div_q;
   logic sck_int_q;
   logic sdo_q;
   logic sck_s_q;
   logic [IRQ_W-1:0] ista_q, ien_q;
   logic aw_q, w_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q, rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] bresp_q, rresp_q;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [2:0] pin_s;
   sspc_sync #(.WIDTH(3)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_i({sdi_i, scs_n_i, sck_i}),
      .sync_o(pin_s)
   );
   wire sck_s = pin_s[0];
   wire scs_n_s = pin_s[1];
   wire sdi_s = pin_s[2];

   ////////////////////////////////////////////////////////////////////////
   // Control decode
   wire en = ctrl_q[SERIAL_INTERFACE_ENABLE_BIT];
   wire master = ctrl_q[MASTER_BIT];
   wire select_pin_enable = ctrl_q[SELECT_PIN_ENABLE_BIT];
   wire msb_first = ctrl_q[MLS_BIT];
   wire clock_edge_select = ctrl_q[CLOCK_EDGE_SELECT_BIT];
   wire ckpol = ctrl_q[CKPOL_BIT];
   wire idle_lvl = ~ckpol;
   // Edge select 1 captures on the edge leaving idle, 0 on the return
   wire cap_leading = clock_edge_select;
   wire sel_ok = ~select_pin_enable | ~scs_n_s;
   wire slave_go = en & ~master & sel_ok;
   wire in_bit = sdi_s;
   wire out_bit = msb_first ? shift_q[7] : shift_q[0];
   wire [7:0] shifted = msb_first ? {shift_q[6:0], in_bit} : {in_bit, shift_q[7:1]};

   // Slave clock edges from the sampled pin
   wire sck_rise = sck_s & ~sck_s_q;
   wire sck_fall = ~sck_s & sck_s_q;
   wire lead_edge = idle_lvl ? sck_fall : sck_rise;
   wire trail_edge = idle_lvl ? sck_rise : sck_fall;
   wire s_cap = slave_go & (cap_leading ? lead_edge : trail_edge);
   wire s_drv = slave_go & busy_q & (cap_leading ? trail_edge : lead_edge);

   // Master divider tick and its edge kinds
   wire tick = (div_q == HALF_DIV);
   wire m_lead = busy_q & master & tick & (st_q != SSPC_TRAIL);
   wire m_trail = busy_q & master & tick & (st_q == SSPC_TRAIL);
   wire m_cap = cap_leading ? m_lead : m_trail;
   wire m_drv = cap_leading ? m_trail : m_lead;
   wire cap = master ? m_cap : s_cap;
   wire last_bit = (cnt_q == BIT_COUNT - 4'h1);
   wire done = cap & last_bit;

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path
   wire wr_fire = aw_q & w_q & ~bvalid_q;
   wire wr_ctrl = wr_fire & (awaddr_q == CTRL_OFS);
   wire wr_data = wr_fire & (awaddr_q == DATA_OFS);
   wire wr_ien = wr_fire & (awaddr_q == IRQ_EN_OFS);
   wire wr_iclr = wr_fire & (awaddr_q == IRQ_STAT_OFS);
   wire wr_ok = wr_ctrl | wr_data | wr_ien | wr_iclr;
   wire lane0 = wstrb_q[0];
   wire data_wr = wr_data & lane0 & en;
   wire collide = data_wr & busy_q;
   wire m_start = data_wr & ~busy_q & master & sel_ok;
   wire clr_trf = wr_ctrl & lane0 & ~wdata_q[TRF_BIT];
   wire clr_write_collision_flag = wr_ctrl & lane0 & ~wdata_q[WRITE_COLLISION_FLAG_BIT];

   assign s_axi_awready = ~aw_q;
   assign s_axi_wready = ~w_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_q) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_q) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path
   wire [7:0] ctrl_view = {ctrl_q[7:3], select_pin_enable, write_collision_flag_q, trf_q};
   wire [7:0] rd_data = (s_axi_araddr == CTRL_OFS) ? ctrl_view :
                        (s_axi_araddr == DATA_OFS) ? data_q :
                        (s_axi_araddr == IRQ_STAT_OFS) ? {6'h00, ista_q} :
                        (s_axi_araddr == IRQ_EN_OFS) ? {6'h00, ien_q} : 8'h00;
   wire rd_ok = (s_axi_araddr == CTRL_OFS) | (s_axi_araddr == DATA_OFS) |
                (s_axi_araddr == IRQ_STAT_OFS) | (s_axi_araddr == IRQ_EN_OFS);
   wire rd_take = s_axi_arvalid & ~rvalid_q;

   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else if (rd_take) begin
         rvalid_q <= 1'b1;
         rdata_q <= {24'h000000, rd_data};
         rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register and flags
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr_ctrl && lane0) begin
         ctrl_q <= wdata_q[CTRL_W-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trf_q <= 1'b0;
         write_collision_flag_q <= 1'b0;
      end else begin
         if (done) begin
            trf_q <= 1'b1;
         end else if (clr_trf || m_start) begin
            trf_q <= 1'b0;
         end
         if (collide) begin
            write_collision_flag_q <= 1'b1;
         end else if (clr_write_collision_flag) begin
            write_collision_flag_q <= 1'b0;
         end
      end
   end

   // Interrupt status: set wins over clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ista_q <= '0;
         ien_q <= '0;
      end else begin
         if (wr_ien && lane0) begin
            ien_q <= wdata_q[IRQ_W-1:0];
         end
         ista_q <= (ista_q & ~((wr_iclr && lane0) ? wdata_q[IRQ_W-1:0] : '0))
                   | {collide, done};
      end
   end
   assign irq = |(ista_q & ien_q);

   ////////////////////////////////////////////////////////////////////////
   // Shift engine
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shift_q <= DATA_RESET;
         data_q <= DATA_RESET;
         cnt_q <= '0;
         busy_q <= 1'b0;
         sdo_q <= 1'b1;
         sck_s_q <= 1'b1;
      end else begin
         sck_s_q <= sck_s;
         if (!en) begin
            busy_q <= 1'b0;
            cnt_q <= '0;
            sdo_q <= 1'b1;
         end else if (data_wr && !busy_q) begin
            shift_q <= wdata_q[7:0];
            data_q <= wdata_q[7:0];
            busy_q <= m_start;
            cnt_q <= '0;
            // First bit ready ahead of the first edge
            sdo_q <= msb_first ? wdata_q[7] : wdata_q[0];
         end else if (!master && !sel_ok) begin
            busy_q <= 1'b0;
            cnt_q <= '0;
            sdo_q <= 1'b1;
         end else if (cap) begin
            shift_q <= shifted;
            cnt_q <= cnt_q + 4'h1;
            if (done) begin
               data_q <= shifted;
               busy_q <= 1'b0;
               cnt_q <= '0;
            end else begin
               busy_q <= 1'b1;
            end
         end else if (m_drv || s_drv) begin
            sdo_q <= out_bit;
         end else if (!busy_q && master) begin
            // Back high one cycle after the last capture edge, past the far capture
            sdo_q <= 1'b1;
         end else if (!busy_q && !master && (lead_edge || trail_edge)) begin
            sdo_q <= out_bit;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Master clock generator
   // Next phase of the master clock
   always_comb begin
      st_d = st_q;
      if (tick) begin
         case (st_q)
            SSPC_IDLE: begin
               st_d = SSPC_TRAIL;
            end
            SSPC_TRAIL: begin
               st_d = SSPC_LEAD;
            end
            default: begin
               st_d = SSPC_TRAIL;
            end
         endcase
      end
   end

   // A transfer ending on a leading edge finishes the half period first
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_q <= '0;
         st_q <= SSPC_IDLE;
         sck_int_q <= 1'b1;
      end else if (!master || !en || (!busy_q && st_q != SSPC_TRAIL)) begin
         div_q <= '0;
         st_q <= SSPC_IDLE;
         sck_int_q <= idle_lvl;
      end else begin
         div_q <= tick ? 8'h00 : div_q + 8'h01;
         if (tick) begin
            sck_int_q <= ~sck_int_q;
            st_q <= st_d;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers
   sspc_pins_s pins;
   assign pins.sck_o = sck_int_q;
   assign pins.sck_oe = en & master;
   assign pins.sdo_o = sdo_q;
   assign pins.sdo_oe = en & (master | sel_ok);
   assign sck_o = pins.sck_o;
   assign sck_oe = pins.sck_oe;
   assign sdo_o = pins.sdo_o;
   assign sdo_oe = pins.sdo_oe;
   assign pins_claimed = en;
endmodule

//--- rtl/sspc_pkg.sv
// Package for the SPI shift port: register map, field positions, types
package sspc_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
   localparam logic [ADDR_W-1:0] DATA_OFS = 4'h4;
   localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 4'h8;
   localparam logic [ADDR_W-1:0] IRQ_EN_OFS = 4'hc;
   localparam logic [ADDR_W-1:0] IRQ_CLR_OFS = 4'h0;
   localparam logic [ADDR_W-1:0] IRQ_CLR2_OFS = 4'h0;
   localparam int unsigned CTRL_W = 8;
   localparam int unsigned TRF_BIT = 0;
   localparam int unsigned WRITE_COLLISION_FLAG_BIT = 1;
   localparam int unsigned SELECT_PIN_ENABLE_BIT = 2;
   localparam int unsigned MLS_BIT = 3;
   localparam int unsigned CLOCK_EDGE_SELECT_BIT = 4;
   localparam int unsigned CKPOL_BIT = 5;
   localparam int unsigned MASTER_BIT = 6;
   localparam int unsigned SERIAL_INTERFACE_ENABLE_BIT = 7;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam int unsigned IRQ_W = 2;
   localparam int unsigned IRQ_TRF = 0;
   localparam int unsigned IRQ_WRITE_COLLISION_FLAG = 1;
   localparam logic [3:0] BIT_COUNT = 4'h8;
   localparam logic [7:0] HALF_DIV = 8'h03;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      SSPC_IDLE = 2'h0,
      SSPC_TRAIL = 2'h1,
      SSPC_LEAD = 2'h3
   } sspc_state_e;

   typedef struct packed {
      logic sck_o;
      logic sck_oe;
      logic sdo_o;
      logic sdo_oe;
   } sspc_pins_s;
endpackage

//--- rtl/sspc_sync.sv
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module sspc_sync #(
   parameter int unsigned WIDTH = 3
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               meta_q[g] <= 1'b1;
               sync_q[g] <= 1'b1;
            end else begin
               meta_q[g] <= async_i[g];
               sync_q[g] <= meta_q[g];
            end
         end
      end
   endgenerate

   assign sync_o = sync_q;
endmodule

//--- testbench/sspc_top_checker.sv
// Concurrent assertions on the ports of the SPI shift port
`timescale 1ns/1ps
module sspc_top_checker
   import sspc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [sspc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic sck_o,
   input wire logic sck_oe,
   input wire logic sdo_o,
   input wire logic sdo_oe,
   input wire logic pins_claimed,
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////////
   a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && sdo_o)
      else $error("outputs not at reset state");
   a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while answer pending");
   a_read_okay: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] == 2'h0
      |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY)
      else $error("mapped read not answered okay");
   a_pins_owned: assert property (sck_oe || sdo_oe |-> pins_claimed || $past(pins_claimed))
      else $error("pin driven while interface off");
   a_pins_free: assert property (!pins_claimed && !$past(pins_claimed) |-> !sck_oe && !sdo_oe)
      else $error("pins not released");
   a_sck_half: assert property (sck_oe && $past(sck_oe) && $changed(sck_o) |=> $stable(sck_o) [*3])
      else $error("clock half period too short");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_irq: cover property ($rose(irq));
   c_sck: cover property ($rose(sck_o) && sck_oe);
endmodule

bind sspc_top sspc_top_checker u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .sck_o(sck_o), .sck_oe(sck_oe), .sdo_o(sdo_o),
   .sdo_oe(sdo_oe), .pins_claimed(pins_claimed), .irq(irq));

//--- testbench/sspc_peer.sv
// Far-side SPI peer: shifts its byte onto sdi and captures sdo
`timescale 1ns/1ps
module sspc_peer (
   input wire logic sck,
   input wire logic scs_n,
   input wire logic sdo,
   input wire logic pol,
   input wire logic eg,
   input wire logic msb,
   input wire logic [7:0] tx,
   output logic sdi,
   output logic [7:0] rx
);
   int cnt;
   function automatic logic pick(input int k);
      return msb ? tx[7-k] : tx[k];
   endfunction
   initial begin
      sdi = 1'b1;
      rx = 8'h00;
      cnt = 0;
   end
   // Frame opens with the first bit ready
   always @(negedge scs_n) begin
      cnt = 0;
      sdi = pick(0);
   end
   // Released line flips so a stale bit cannot pass
   always @(posedge scs_n) sdi = ~sdi;
   always @(sck) begin
      if (!scs_n && (sck == (pol == eg))) begin
         rx = msb ? {rx[6:0], sdo} : {sdo, rx[7:1]};
         cnt++;
      end else if (!scs_n && cnt < 8) begin
         sdi = pick(cnt);
      end
   end
endmodule

//--- testbench/spi_shift_port_control_test.sv
// Register-level bench for the SPI shift port
`timescale 1ns/1ps
module spi_shift_port_control_test;
   import sspc_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic sck_i, sck_o, sck_oe, scs_n_i, sdi_i, sdo_o, sdo_oe, pins_claimed, irq;
   logic ext_sck, pol, eg, msb, sdo_w;
   logic [7:0] ptx, prx;
   int n_errors, checked;
   assign sck_i = sck_oe ? sck_o : ext_sck;
   assign sdo_w = sdo_oe ? sdo_o : ~sdo_o;
   always #20 aclk = ~aclk;
   sspc_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .sck_i, .sck_o, .sck_oe, .scs_n_i, .sdi_i, .sdo_o, .sdo_oe, .pins_claimed,
      .irq);
   sspc_peer peer (.sck(sck_i), .scs_n(scs_n_i), .sdo(sdo_w), .pol(pol), .eg(eg), .msb(msb),
      .tx(ptx), .sdi(sdi_i), .rx(prx));
   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      logic aw, w, b;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         {aw, w, b} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (b) s_axi_bready <= 1'b0;
         n++;
      end while (!b && n < 100);
      if (!b) begin
         n_errors++;
         summarize();
      end
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic ar, v;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         {ar, v, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'b0;
         if (v) s_axi_rready <= 1'b0;
         n++;
      end while (!v && n < 100);
      if (!v) begin
         n_errors++;
         summarize();
      end
   endtask
   task automatic chk(input logic [3:0] a, input logic [31:0] e, input string nm);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      cmp(nm, e, d);
   endtask
   task automatic wait_done;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      n = 0;
      do begin
         rd(CTRL_OFS, d, r);
         n++;
      end while (!d[TRF_BIT] && n < 50);
      if (!d[TRF_BIT]) begin
         n_errors++;
         summarize();
      end
      @(negedge aclk);
   endtask
   // Eight external clock pulses at the link rate, select left as the caller set it
   task automatic frame;
      repeat (2) @(posedge aclk);
      repeat (16) begin
         repeat (4) @(posedge aclk);
         ext_sck <= ~ext_sck;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [7:0] cfg, dtx;
      logic m;
      {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 6'h00;
      {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_wstrb, scs_n_i, ext_sck, pol, eg, msb, ptx} = {4'h1, 5'h1f, 8'h00};
      {n_errors, checked} = '0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      chk(CTRL_OFS, 32'(CTRL_RESET), "ctrl reset");
      chk(DATA_OFS, 32'(DATA_RESET), "data reset");
      rd(4'h6, d, r);
      cmp("unmapped resp", 32'(RESP_SLVERR), 32'(r));
      for (int i = 0; i < 8; i++) begin
         {m, pol, eg, msb} = {~i[2], i[0], i[1], i[0] ^ i[2]};
         cfg = {1'b1, m, pol, eg, msb, 3'h4};
         dtx = 8'h1e + 8'(i * 7);
         wr(IRQ_EN_OFS, 32'(i[0]));
         ext_sck <= !pol;
         wr(CTRL_OFS, 32'(cfg));
         @(negedge aclk);
         ptx = 8'hb4 ^ 8'(i * 3);
         cmp("sdo idle", 32'h1, 32'(sdo_o));
         cmp("sck owner", 32'(m), 32'(sck_oe));
         if (m) cmp("sck idle", 32'(!pol), 32'(sck_o));
         @(posedge aclk);
         scs_n_i <= 1'b0;
         wr(DATA_OFS, 32'(dtx));
         if (m) wr(DATA_OFS, 32'(~dtx));
         if (m) chk(CTRL_OFS, 32'({cfg[7:2], 2'h2}), "busy flags");
         else frame();
         wait_done();
         cmp("irq raised", 32'(i[0]), 32'(irq));
         chk(DATA_OFS, 32'(ptx), "rx byte");
         cmp("peer rx", 32'(dtx), 32'(prx));
         chk(CTRL_OFS, 32'({cfg[7:2], m, 1'b1}), "done flags");
         chk(IRQ_STAT_OFS, 32'({m, 1'b1}), "irq status");
         wr(CTRL_OFS, 32'(cfg));
         wr(IRQ_STAT_OFS, 32'h3);
         scs_n_i <= 1'b1;
         @(negedge aclk);
         cmp("irq cleared", 32'h0, 32'(irq));
      end
      // Select pin disabled: slave shifts with select left high; select pin enabled: no shift
      @(posedge aclk);
      ext_sck <= 1'b1;
      repeat (3) @(posedge aclk);
      wr(CTRL_OFS, 32'h80);
      frame();
      wait_done();
      chk(IRQ_STAT_OFS, 32'h1, "free select");
      wr(CTRL_OFS, 32'h84);
      frame();
      chk(CTRL_OFS, 32'h84, "no select");
      wr(CTRL_OFS, 32'h0);
      @(negedge aclk);
      cmp("released", 32'h0, 32'({pins_claimed, sck_oe, sdo_oe}));
      summarize();
   end
endmodule
